// ---- flash_mode_pkg.sv ----
// Shared constants, register map and mode types of the flash and torch mode controller.
// Assumes a single 125 MHz clock and a byte-wide register port fed by the serial front end.
package flash_mode_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_PRIVACY = 8'h11;
	localparam logic [7:0] ADDR_GPIO = 8'h20;
	localparam logic [7:0] ADDR_CONFIG1 = 8'h80;
	localparam logic [7:0] ADDR_TORCH = 8'ha0;
	localparam logic [7:0] ADDR_FLASH = 8'hb0;
	localparam logic [7:0] ADDR_DURATION = 8'hc0;
	localparam logic [7:0] ADDR_FLAGS = 8'hd0;
	localparam logic [7:0] ADDR_CONFIG2 = 8'hf0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ENABLE_RESET = 8'h18;
	localparam logic [7:0] PRIVACY_RESET = 8'h00;
	localparam logic [7:0] GPIO_RESET = 8'h00;
	localparam logic [7:0] CONFIG1_RESET = 8'h20;
	localparam logic [7:0] CONFIG2_RESET = 8'h00;
	localparam logic [7:0] TORCH_RESET = 8'h00;
	localparam logic [7:0] FLASH_RESET = 8'h00;
	localparam logic [7:0] DURATION_RESET = 8'h0f;

	// ==========================================================
	// Field positions
	localparam int ENA_PRIV_HIGH_BIT = 2;
	localparam int ENA_SRC_A_BIT = 3;
	localparam int ENA_EDGE_BIT = 5;
	localparam int PRIV_TERM_BIT = 3;
	localparam int PRIV_SRC_A_BIT = 4;
	localparam int PRIV_BLINK_LSB = 6;
	localparam int CFG1_STROBE_EN_BIT = 2;
	localparam int CFG1_POLARITY_BIT = 5;
	localparam int CFG1_HWTORCH_BIT = 7;
	localparam int CFG2_SHUTDOWN_BIT = 4;
	localparam int GPIO_A_EN_BIT = 0;
	localparam int GPIO_A_DIR_BIT = 1;
	localparam int GPIO_A_VAL_BIT = 2;
	localparam int GPIO_B_EN_BIT = 3;
	localparam int GPIO_B_DIR_BIT = 4;
	localparam int GPIO_B_VAL_BIT = 5;
	localparam int GPIO_B_INT_BIT = 6;
	localparam int FLAG_TIMEOUT_BIT = 0;
	localparam int FLAG_SYNC_BIT = 1;

	// ==========================================================
	// Mode field codes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_PRIVACY = 2'h1;
	localparam logic [1:0] MODE_TORCH = 2'h2;
	localparam logic [1:0] MODE_FLASH = 2'h3;

	// ==========================================================
	// Current ladder and timing
	localparam logic [4:0] FLASH_LADDER_BASE = 5'h08;
	localparam logic [4:0] TORCH_LEVEL_LOW = 5'h00;
	localparam logic [4:0] TORCH_LEVEL_HIGH = 5'h07;
	localparam int CLK_FREQ_MHZ = 125;
	localparam int RAMP_STEP_NS = 32000;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int TIMEOUT_STEP_MS = 32;
	localparam logic [14:0] TIMEOUT_STEP_TICKS = 15'(TIMEOUT_STEP_MS * 1000000 / RAMP_STEP_NS);
	localparam int BLINK_BASE_MS = 128;
	localparam logic [13:0] BLINK_BASE_TICKS = 14'(BLINK_BASE_MS * 1000000 / RAMP_STEP_NS);
	localparam logic [3:0] PWM_STEPS = 4'ha;

	typedef enum logic [1:0] {ST_OFF, ST_PRIVACY, ST_TORCH, ST_FLASH} state_t;

endpackage

// ---- sync_line_if.sv ----
// Carrier for one synchronised input: its active level and its active edge.
// Assumes producer and consumer share mclk_in.
`timescale 1ns/1ps
interface sync_line_if;
	logic active;
	logic edge_seen;
	modport src (output active, output edge_seen);
	modport dst (input active, input edge_seen);
endinterface

// ---- input_sync.sv ----
// Two-stage synchroniser with polarity selection and active-edge detection.
// Assumes the pin is asynchronous to mclk_in.
`timescale 1ns/1ps
module input_sync
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic pin_in,
	input wire logic active_high_in,
	sync_line_if.src line
);
	logic meta_q;
	logic stable_q;
	logic prev_q;
	logic act;

	// ==========================================================
	// Synchroniser
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			meta_q <= 1'b0;
			stable_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin_in;
			stable_q <= meta_q;
		end
	end

	assign act = active_high_in ? stable_q : ~stable_q;

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			prev_q <= 1'b0;
		else
			prev_q <= act;
	end

	assign line.active = act;
	assign line.edge_seen = act & ~prev_q;
endmodule

// ---- tick_divider.sv ----
// Divider that gives a one-cycle enable pulse every COUNT clock cycles.
// Assumes COUNT is at least two.
`timescale 1ns/1ps
module tick_divider
#(
	parameter int COUNT = 4000
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	output logic tick_out
);
	logic [15:0] cnt_q;

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			cnt_q <= 16'h0000;
			tick_out <= 1'b0;
		end
		else if (cnt_q == 16'(COUNT - 1))
		begin
			cnt_q <= 16'h0000;
			tick_out <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule

// ---- flash_mode_ctrl.sv ----
// Mode control of a two-source flash LED driver: flash, torch, privacy, sync pins.
// Assumes a byte register port already decoded from the serial interface, and pins
// that are asynchronous to mclk_in.
`timescale 1ns/1ps
module flash_mode_ctrl
#(
	parameter int PWM_STEP_CYCLES = 125
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic flash_strobe_in,
	input wire logic pa_sync_pin_a_in,
	output logic pa_sync_pin_a_out,
	output logic pa_sync_pin_a_oe_n_out,
	input wire logic pa_sync_pin_b_in,
	output logic pa_sync_pin_b_out,
	output logic pa_sync_pin_b_oe_n_out,
	output logic source_a_on_out,
	output logic [4:0] source_a_current_out,
	output logic source_b_on_out,
	output logic [4:0] source_b_current_out
);
	import flash_mode_pkg::*;

	logic [7:0] enable_q;
	logic [7:0] privacy_q;
	logic [7:0] gpio_q;
	logic [7:0] config1_q;
	logic [7:0] config2_q;
	logic [7:0] torch_q;
	logic [7:0] flashbr_q;
	logic [7:0] duration_q;
	logic [7:0] flags_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	state_t state_q;
	state_t state_d;
	logic from_priv_q;
	logic by_strobe_q;
	logic shut_q;
	logic armed_q;
	logic blink_on_q;
	logic [14:0] to_cnt_q;
	logic [14:0] to_limit;
	logic [13:0] blink_cnt_q;
	logic [13:0] blink_half;
	logic [3:0] pwm_cnt_q;
	logic [4:0] lvl_q [2];
	logic [4:0] tgt [2];
	logic [1:0] sel;
	logic [1:0] gate;
	logic [1:0] on_q;
	logic pin_a_out_q;
	logic pin_a_oe_n_q;
	logic pin_b_out_q;
	logic pin_b_oe_n_q;
	logic ramp_tick;
	logic pwm_tick;
	logic pin_a_gpio;
	logic hw_torch_mode;
	logic amp_a_mode;
	logic sync_a_act;
	logic sync_b_act;
	logic force_low;
	logic shut_edge;
	logic flags_rd;
	logic wr_en;
	logic strobe_go;
	logic to_hit;
	logic level_end;
	logic retoggle;
	logic flash_done;
	logic flash_exit;
	logic pwm_on;

	sync_line_if strobe_line ();
	sync_line_if amp_a_line ();
	sync_line_if amp_b_line ();

	// ==========================================================
	// Input synchronisers and time bases
	input_sync strobe_sync
	(
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(flash_strobe_in),
		.active_high_in(1'b1),
		.line(strobe_line.src)
	);

	input_sync amp_a_sync
	(
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(pa_sync_pin_a_in),
		.active_high_in(~amp_a_mode | config1_q[CFG1_POLARITY_BIT]),
		.line(amp_a_line.src)
	);

	input_sync amp_b_sync
	(
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(pa_sync_pin_b_in),
		.active_high_in(1'b1),
		.line(amp_b_line.src)
	);

	tick_divider #(.COUNT(RAMP_STEP_CYCLES)) ramp_div
	(
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.tick_out(ramp_tick)
	);

	tick_divider #(.COUNT(PWM_STEP_CYCLES)) pwm_div
	(
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.tick_out(pwm_tick)
	);

	// ==========================================================
	// Ramp step toward a target, dropping at once when above it
	function automatic logic [4:0] ramp_next(input logic [4:0] lvl, input logic [4:0] goal,
		input logic step);
		logic [4:0] r;
		r = lvl;
		if (lvl >= goal)
			r = goal;
		else if (step)
			r = lvl + 5'h01;
		return r;
	endfunction

	// ==========================================================
	// Pin function decode and events
	assign pin_a_gpio = gpio_q[GPIO_A_EN_BIT];
	assign hw_torch_mode = ~pin_a_gpio & config1_q[CFG1_HWTORCH_BIT];
	assign amp_a_mode = ~pin_a_gpio & ~config1_q[CFG1_HWTORCH_BIT];
	assign sync_a_act = amp_a_mode & amp_a_line.active;
	assign sync_b_act = ~gpio_q[GPIO_B_EN_BIT] & amp_b_line.active;
	assign force_low = sync_a_act | sync_b_act;
	assign shut_edge = (state_q == ST_FLASH) & config2_q[CFG2_SHUTDOWN_BIT] & amp_a_mode
		& amp_a_line.edge_seen & armed_q;
	assign flags_rd = reg_rd_in & (reg_addr_in == ADDR_FLAGS);
	assign wr_en = reg_wr_in & (reg_addr_in == ADDR_ENABLE);
	assign strobe_go = config1_q[CFG1_STROBE_EN_BIT] & strobe_line.edge_seen;
	assign to_limit = 15'(({10'h000, duration_q[4:0]} + 15'h0001) * TIMEOUT_STEP_TICKS);
	assign to_hit = (state_q == ST_FLASH) & (to_cnt_q >= to_limit);
	assign level_end = (state_q == ST_FLASH) & by_strobe_q & ~enable_q[ENA_EDGE_BIT]
		& ~strobe_line.active;
	assign retoggle = by_strobe_q & ~enable_q[ENA_EDGE_BIT] & strobe_line.edge_seen;
	assign flash_done = to_hit | level_end;
	assign flash_exit = (state_q == ST_FLASH) & (state_d != ST_FLASH);

	// ==========================================================
	// Mode selection
	always_comb
	begin
		if (enable_q[1:0] == MODE_FLASH)
			state_d = ST_FLASH;
		else if (enable_q[1:0] == MODE_TORCH || (hw_torch_mode && amp_a_line.active))
			state_d = ST_TORCH;
		else if (enable_q[1:0] == MODE_PRIVACY)
			state_d = ST_PRIVACY;
		else
			state_d = ST_OFF;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			state_q <= ST_OFF;
		else
			state_q <= state_d;
	end

	// ==========================================================
	// Control registers written by software
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			enable_q <= ENABLE_RESET;
		else
		begin
			if (wr_en)
				enable_q <= reg_wdata_in;
			if (strobe_go)
				enable_q[1:0] <= MODE_FLASH;
			if (flash_done)
				enable_q[1:0] <= (~privacy_q[PRIV_TERM_BIT] & from_priv_q) ? MODE_PRIVACY
					: MODE_OFF;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			config1_q <= CONFIG1_RESET;
		else
		begin
			if (reg_wr_in && reg_addr_in == ADDR_CONFIG1)
				config1_q <= reg_wdata_in;
			if (flash_exit && hw_torch_mode)
				config1_q[CFG1_HWTORCH_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			privacy_q <= PRIVACY_RESET;
			gpio_q <= GPIO_RESET;
			config2_q <= CONFIG2_RESET;
			torch_q <= TORCH_RESET;
			flashbr_q <= FLASH_RESET;
			duration_q <= DURATION_RESET;
		end
		else if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				ADDR_PRIVACY: privacy_q <= reg_wdata_in;
				ADDR_GPIO: gpio_q <= reg_wdata_in;
				ADDR_CONFIG2: config2_q <= reg_wdata_in;
				ADDR_TORCH: torch_q <= reg_wdata_in;
				ADDR_FLASH: flashbr_q <= reg_wdata_in;
				ADDR_DURATION: duration_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Flags, cleared by reading; a new event in the read cycle wins
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			flags_q <= 8'h00;
		else
		begin
			if (flags_rd)
				flags_q <= 8'h00;
			if (to_hit)
				flags_q[FLAG_TIMEOUT_BIT] <= 1'b1;
			if ((state_q == ST_FLASH) && (amp_a_line.edge_seen && amp_a_mode))
				flags_q[FLAG_SYNC_BIT] <= 1'b1;
		end
	end

	// ==========================================================
	// Register read port
	always_comb
	begin
		rdata_d = 8'h00;
		unique case (reg_addr_in)
			ADDR_ENABLE: rdata_d = enable_q;
			ADDR_PRIVACY: rdata_d = privacy_q;
			ADDR_GPIO: rdata_d = {gpio_q[7:6],
				gpio_q[GPIO_B_DIR_BIT] ? gpio_q[GPIO_B_VAL_BIT] : amp_b_line.active,
				gpio_q[4:3],
				gpio_q[GPIO_A_DIR_BIT] ? gpio_q[GPIO_A_VAL_BIT] : amp_a_line.active,
				gpio_q[1:0]};
			ADDR_CONFIG1: rdata_d = config1_q;
			ADDR_CONFIG2: rdata_d = config2_q;
			ADDR_TORCH: rdata_d = torch_q;
			ADDR_FLASH: rdata_d = flashbr_q;
			ADDR_DURATION: rdata_d = duration_q;
			ADDR_FLAGS: rdata_d = flags_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (reg_rd_in)
			rdata_q <= rdata_d;
	end

	// ==========================================================
	// Flash sequencing: timeout, strobe origin, sync shutdown
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			to_cnt_q <= 15'h0000;
		else if (state_q != ST_FLASH || retoggle)
			to_cnt_q <= 15'h0000;
		else if (ramp_tick && !to_hit)
			to_cnt_q <= to_cnt_q + 15'h0001;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			by_strobe_q <= 1'b0;
			from_priv_q <= 1'b0;
		end
		else
		begin
			if (strobe_go)
				by_strobe_q <= 1'b1;
			else if ((wr_en && reg_wdata_in[1:0] == MODE_FLASH) || state_d != ST_FLASH)
				by_strobe_q <= 1'b0;
			if (state_d == ST_FLASH && state_q != ST_FLASH)
				from_priv_q <= (state_q == ST_PRIVACY);
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			shut_q <= 1'b0;
			armed_q <= 1'b1;
		end
		else
		begin
			if (flags_rd || state_q != ST_FLASH)
				shut_q <= 1'b0;
			if (flags_rd)
				armed_q <= 1'b1;
			if (shut_edge)
			begin
				shut_q <= 1'b1;
				armed_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Privacy PWM and blink
	assign pwm_on = (pwm_cnt_q <= {1'b0, privacy_q[2:0]});
	assign blink_half = BLINK_BASE_TICKS << privacy_q[PRIV_BLINK_LSB +: 2];

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			pwm_cnt_q <= 4'h0;
		else if (state_q != ST_PRIVACY)
			pwm_cnt_q <= 4'h0;
		else if (pwm_tick)
			pwm_cnt_q <= (pwm_cnt_q == PWM_STEPS - 4'h1) ? 4'h0 : pwm_cnt_q + 4'h1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			blink_cnt_q <= 14'h0000;
			blink_on_q <= 1'b1;
		end
		else if (state_q != ST_PRIVACY || privacy_q[PRIV_BLINK_LSB +: 2] == 2'h3)
		begin
			blink_cnt_q <= 14'h0000;
			blink_on_q <= 1'b1;
		end
		else if (ramp_tick)
		begin
			if (blink_cnt_q >= blink_half - 14'h0001)
			begin
				blink_cnt_q <= 14'h0000;
				blink_on_q <= ~blink_on_q;
			end
			else
				blink_cnt_q <= blink_cnt_q + 14'h0001;
		end
	end

	// ==========================================================
	// Per-source targets
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			sel[i] = 1'b0;
			gate[i] = 1'b0;
			tgt[i] = TORCH_LEVEL_LOW;
			unique case (state_q)
				ST_TORCH:
				begin
					sel[i] = enable_q[ENA_SRC_A_BIT + i];
					gate[i] = 1'b1;
					tgt[i] = {2'b00, torch_q[3 * i +: 3]};
				end
				ST_FLASH:
				begin
					sel[i] = enable_q[ENA_SRC_A_BIT + i];
					gate[i] = ~shut_q & ~to_hit;
					tgt[i] = force_low ? {2'b00, torch_q[3 * i +: 3]}
						: FLASH_LADDER_BASE + {1'b0, flashbr_q[4 * i +: 4]};
				end
				ST_PRIVACY:
				begin
					sel[i] = privacy_q[PRIV_SRC_A_BIT + i];
					gate[i] = pwm_on & blink_on_q;
					tgt[i] = enable_q[ENA_PRIV_HIGH_BIT] ? TORCH_LEVEL_HIGH : TORCH_LEVEL_LOW;
				end
				ST_OFF: ;
			endcase
		end
	end

	// ==========================================================
	// Current ramp, one ladder level per step
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			lvl_q[0] <= 5'h00;
			lvl_q[1] <= 5'h00;
			on_q <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (!sel[i] || state_q != state_d)
					lvl_q[i] <= 5'h00;
				else
					lvl_q[i] <= ramp_next(lvl_q[i], tgt[i], ramp_tick);
				on_q[i] <= sel[i] & gate[i] & (state_q == state_d);
			end
		end
	end

	// ==========================================================
	// Multi-function pin drivers
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			pin_a_out_q <= 1'b0;
			pin_a_oe_n_q <= 1'b1;
			pin_b_out_q <= 1'b0;
			pin_b_oe_n_q <= 1'b1;
		end
		else
		begin
			pin_a_oe_n_q <= ~(pin_a_gpio & gpio_q[GPIO_A_DIR_BIT]);
			pin_a_out_q <= pin_a_gpio & gpio_q[GPIO_A_DIR_BIT] & gpio_q[GPIO_A_VAL_BIT];
			pin_b_oe_n_q <= ~(gpio_q[GPIO_B_EN_BIT] & gpio_q[GPIO_B_DIR_BIT]);
			if (gpio_q[GPIO_B_INT_BIT])
				pin_b_out_q <= ~(|flags_q);
			else
				pin_b_out_q <= gpio_q[GPIO_B_EN_BIT] & gpio_q[GPIO_B_DIR_BIT]
					& gpio_q[GPIO_B_VAL_BIT];
		end
	end

	assign reg_rdata_out = rdata_q;
	assign pa_sync_pin_a_out = pin_a_out_q;
	assign pa_sync_pin_a_oe_n_out = pin_a_oe_n_q;
	assign pa_sync_pin_b_out = pin_b_out_q;
	assign pa_sync_pin_b_oe_n_out = pin_b_oe_n_q;
	assign source_a_on_out = on_q[0];
	assign source_a_current_out = lvl_q[0];
	assign source_b_on_out = on_q[1];
	assign source_b_current_out = lvl_q[1];
endmodule

// ---- flash_mode_chk.sv ----
// Port checker of the flash and torch mode controller.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/1ps
module flash_mode_chk
import flash_mode_pkg::*;
#(
	parameter int PWM_STEP_CYCLES = 125
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic flash_strobe_in,
	input wire logic pa_sync_pin_a_in,
	input wire logic pa_sync_pin_a_out,
	input wire logic pa_sync_pin_a_oe_n_out,
	input wire logic pa_sync_pin_b_out,
	input wire logic pa_sync_pin_b_oe_n_out,
	input wire logic source_a_on_out,
	input wire logic [4:0] source_a_current_out,
	input wire logic source_b_on_out
);
	// ====================================
	// Ramp step spacing helper.
	logic [4:0] lvl_q;
	logic on_q;
	logic seen_q;
	logic [12:0] gap_q;
	logic inc;
	assign inc = on_q && source_a_on_out && (source_a_current_out > lvl_q);
	always_ff @(posedge mclk_in)
	begin
		lvl_q <= source_a_current_out;
		on_q <= source_a_on_out;
	end
	always_ff @(posedge mclk_in)
	begin
		gap_q <= (rst_in || inc) ? 13'h0 : gap_q + 13'h1;
	end
	always_ff @(posedge mclk_in)
	begin
		if (rst_in || !source_a_on_out || source_a_current_out < lvl_q)
			seen_q <= 1'b0;
		else if (inc)
			seen_q <= 1'b1;
		else if (gap_q == 13'(RAMP_STEP_CYCLES))
			seen_q <= 1'b0;
	end
	// ====================================
	// Assertions.
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	a_reset_idle: assert property ($fell(rst_in) |-> !source_a_on_out &&
		!source_b_on_out && pa_sync_pin_a_oe_n_out && pa_sync_pin_b_oe_n_out)
		else $error("outputs not idle after reset");
	a_ramp_single: assert property (inc |-> source_a_current_out == lvl_q + 5'h1)
		else $error("ramp skipped a level");
	a_ramp_spacing: assert property (inc && seen_q |-> gap_q == 13'(RAMP_STEP_CYCLES - 1))
		else $error("ramp step spacing wrong");
	a_ladder_top: assert property (source_a_on_out |-> source_a_current_out <= 5'h17)
		else $error("level beyond ladder");
	a_gpio_a_drive: assert property (reg_wr_in && reg_addr_in == 8'h20 &&
		reg_wdata_in[2:0] == 3'h7 |-> ##[1:3] (!pa_sync_pin_a_oe_n_out && pa_sync_pin_a_out))
		else $error("pin a not driven high");
	a_gpio_b_drive: assert property (reg_wr_in && reg_addr_in == 8'h20 &&
		reg_wdata_in[6:3] == 4'h7 |-> ##[1:3] (!pa_sync_pin_b_oe_n_out && pa_sync_pin_b_out))
		else $error("pin b not driven high");
	a_mode_off_dark: assert property (reg_wr_in && reg_addr_in == 8'h10 &&
		reg_wdata_in[1:0] == 2'h0 |-> ##[1:4] (!source_a_on_out && !source_b_on_out))
		else $error("sources on after mode off");
	a_sync_first: assert property ($rose(flash_strobe_in) || $rose(pa_sync_pin_a_in)
		|=> $stable(source_a_on_out))
		else $error("pin acted before synchronising");
endmodule

bind flash_mode_ctrl flash_mode_chk #(.PWM_STEP_CYCLES(PWM_STEP_CYCLES)) chk_u (
	.mclk_in(mclk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.flash_strobe_in(flash_strobe_in), .pa_sync_pin_a_in(pa_sync_pin_a_in),
	.pa_sync_pin_a_out(pa_sync_pin_a_out), .pa_sync_pin_a_oe_n_out(pa_sync_pin_a_oe_n_out),
	.pa_sync_pin_b_out(pa_sync_pin_b_out), .pa_sync_pin_b_oe_n_out(pa_sync_pin_b_oe_n_out),
	.source_a_on_out(source_a_on_out), .source_a_current_out(source_a_current_out),
	.source_b_on_out(source_b_on_out));

// ---- pa_pin_model.sv ----
// Far-side model of the amplifier controller on both multi-function pins.
// Assumes the bench changes drive requests away from the clock edge.
`timescale 1ns/1ps
module pa_pin_model
(
	input wire logic mclk_in,
	input wire logic a_en_in,
	input wire logic a_val_in,
	input wire logic b_en_in,
	input wire logic b_val_in,
	input wire logic a_oe_n_in,
	input wire logic a_dut_in,
	input wire logic b_oe_n_in,
	input wire logic b_dut_in,
	output logic pin_a_out,
	output logic pin_b_out
);
	// ====================================
	// Pin resolution; an undriven line has no pull and wanders.
	logic float_q = 1'b0;
	always_ff @(posedge mclk_in)
		float_q <= ~float_q;
	assign pin_a_out = !a_oe_n_in ? a_dut_in : (a_en_in ? a_val_in : float_q);
	assign pin_b_out = !b_oe_n_in ? b_dut_in : (b_en_in ? b_val_in : ~float_q);
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the flash and torch mode controller.
// Assumes the package constants and a 125 MHz clock.
`timescale 1ns/1ps
module tb_top;
	import flash_mode_pkg::*;
	logic mclk, rst, wr, rd, strobe, a_en, a_val, b_en, b_val;
	logic [7:0] addr, wdata, rdata, got;
	logic pin_a, pin_b, a_out, a_oe_n, b_out, b_oe_n, a_on, b_on;
	logic [4:0] a_cur, b_cur;
	int n_fail, checks_done, cyc, n_a, n_b, n_bad;
	logic [7:0] ra [6] = '{8'h10, 8'h11, 8'h20, 8'h80, 8'hc0, 8'h55};
	logic [7:0] rv [6] = '{8'h18, 8'h00, 8'h00, 8'h20, 8'h0f, 8'h00};
	// ====================================
	// Design and far side.
	flash_mode_ctrl #(.PWM_STEP_CYCLES(4)) dut_u (.mclk_in(mclk), .rst_in(rst),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .flash_strobe_in(strobe), .pa_sync_pin_a_in(pin_a),
		.pa_sync_pin_a_out(a_out), .pa_sync_pin_a_oe_n_out(a_oe_n), .pa_sync_pin_b_in(pin_b),
		.pa_sync_pin_b_out(b_out), .pa_sync_pin_b_oe_n_out(b_oe_n), .source_a_on_out(a_on),
		.source_a_current_out(a_cur), .source_b_on_out(b_on), .source_b_current_out(b_cur));
	pa_pin_model far_u (.mclk_in(mclk), .a_en_in(a_en), .a_val_in(a_val), .b_en_in(b_en),
		.b_val_in(b_val), .a_oe_n_in(a_oe_n), .a_dut_in(a_out), .b_oe_n_in(b_oe_n),
		.b_dut_in(b_out), .pin_a_out(pin_a), .pin_b_out(pin_b));
	// ====================================
	// Tasks.
	task stop_test;
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk_v(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task chk_n(input string what, input int exp, input int seen);
		checks_done++;
		if (seen != exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge mclk);
		wr = 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		rd = 1'b1;
		addr = a;
		@(negedge mclk);
		rd = 1'b0;
		@(negedge mclk);
		d = rdata;
	endtask
	task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a, got);
		chk_v(what, exp, got);
	endtask
	task wait_lvl(input logic b, input logic [4:0] want, input int lim);
		for (int i = 0; i < lim; i++)
		begin
			if ((b ? b_cur : a_cur) === want)
				break;
			@(negedge mclk);
		end
	endtask
	// ====================================
	// Clock and hang guard.
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_fail++;
			stop_test();
		end
	end
	// ====================================
	// Main sequence.
	initial
	begin
		{rst, a_en, b_en} = 3'h7;
		{wr, rd, strobe, a_val, b_val} = 5'h0;
		{addr, wdata} = 16'h0;
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		foreach (ra[i])
			rd_chk("reset value", ra[i], rv[i]);
		wr_reg(ADDR_TORCH, 8'h2a);
		wr_reg(ADDR_ENABLE, 8'h1a);
		wait_lvl(1'b0, 5'h02, 3 * RAMP_STEP_CYCLES + 50);
		chk_v("torch a", 8'h02, {3'h0, a_cur});
		wait_lvl(1'b1, 5'h05, 3 * RAMP_STEP_CYCLES + 50);
		chk_v("torch b", 8'h05, {3'h0, b_cur});
		chk_v("torch a held", 8'h02, {3'h0, a_cur});
		rd_chk("enable", ADDR_ENABLE, 8'h1a);
		wr_reg(ADDR_ENABLE, 8'h18);
		wr_reg(ADDR_TORCH, 8'h28);
		wr_reg(ADDR_ENABLE, 8'h1b);
		wait_lvl(1'b0, 5'h02, 3 * RAMP_STEP_CYCLES + 50);
		chk_v("flash ramp", 8'h02, {3'h0, a_cur});
		a_val = 1'b1;
		repeat (8) @(negedge mclk);
		chk_v("sync torch", 8'h00, {3'h0, a_cur});
		a_val = 1'b0;
		wait_lvl(1'b0, 5'h01, RAMP_STEP_CYCLES + 50);
		chk_v("sync release", 8'h01, {3'h0, a_cur});
		b_val = 1'b1;
		repeat (8) @(negedge mclk);
		chk_v("pin b torch", 8'h00, {3'h0, a_cur});
		b_val = 1'b0;
		wait_lvl(1'b0, 5'h01, RAMP_STEP_CYCLES + 50);
		chk_v("pin b release", 8'h01, {3'h0, a_cur});
		wr_reg(ADDR_CONFIG1, 8'h00);
		repeat (8) @(negedge mclk);
		chk_v("low polarity", 8'h00, {3'h0, a_cur});
		wr_reg(ADDR_CONFIG1, 8'h20);
		wr_reg(ADDR_ENABLE, 8'h18);
		rd_reg(ADDR_FLAGS, got);
		wr_reg(ADDR_CONFIG2, 8'h10);
		wr_reg(ADDR_ENABLE, 8'h1b);
		repeat (20) @(negedge mclk);
		a_val = 1'b1;
		repeat (8) @(negedge mclk);
		chk_v("shutdown", 8'h00, {7'h0, a_on});
		rd_chk("flags", ADDR_FLAGS, 8'h02);
		repeat (8) @(negedge mclk);
		chk_v("held torch", 8'h01, {7'h0, a_on});
		a_val = 1'b0;
		repeat (6) @(negedge mclk);
		rd_reg(ADDR_FLAGS, got);
		a_val = 1'b1;
		repeat (8) @(negedge mclk);
		chk_v("rearmed", 8'h00, {7'h0, a_on});
		a_val = 1'b0;
		wr_reg(ADDR_ENABLE, 8'h18);
		wr_reg(ADDR_CONFIG2, 8'h00);
		rd_reg(ADDR_FLAGS, got);
		wr_reg(ADDR_CONFIG1, 8'ha4);
		a_val = 1'b1;
		repeat (10) @(negedge mclk);
		chk_v("hw torch", 8'h01, {7'h0, a_on});
		strobe = 1'b1;
		repeat (40) @(negedge mclk);
		rd_chk("strobe flash", ADDR_ENABLE, 8'h1b);
		strobe = 1'b0;
		repeat (10) @(negedge mclk);
		chk_v("flash end", 8'h00, {7'h0, a_on});
		rd_chk("hw bit clear", ADDR_CONFIG1, 8'h24);
		rd_chk("mode clear", ADDR_ENABLE, 8'h18);
		wr_reg(ADDR_CONFIG1, 8'ha0);
		repeat (10) @(negedge mclk);
		chk_v("hw torch again", 8'h01, {7'h0, a_on});
		a_val = 1'b0;
		wr_reg(ADDR_CONFIG1, 8'h20);
		wr_reg(ADDR_ENABLE, 8'h19);
		for (int d = 0; d < 8; d++)
		begin
			wr_reg(ADDR_PRIVACY, 8'hd0 | 8'(d));
			repeat (80) @(negedge mclk);
			{n_a, n_b, n_bad} = 0;
			repeat (400)
			begin
				@(negedge mclk);
				n_a += (a_on === 1'b1);
				n_b += (b_on === 1'b1);
				n_bad += (a_on === 1'b1 && a_cur !== TORCH_LEVEL_LOW);
			end
			chk_n("privacy duty", (d + 1) * 40, n_a);
			chk_n("privacy source b", 0, n_b);
			chk_n("privacy level", 0, n_bad);
		end
		wr_reg(ADDR_ENABLE, 8'h1d);
		wait_lvl(1'b0, TORCH_LEVEL_HIGH, 8 * RAMP_STEP_CYCLES + 50);
		chk_v("privacy high", {3'h0, TORCH_LEVEL_HIGH}, {3'h0, a_cur});
		wr_reg(ADDR_PRIVACY, 8'hc0);
		wr_reg(ADDR_CONFIG1, 8'h24);
		strobe = 1'b1;
		repeat (10) @(negedge mclk);
		strobe = 1'b0;
		repeat (10) @(negedge mclk);
		rd_chk("privacy resume", ADDR_ENABLE, 8'h1d);
		wr_reg(ADDR_ENABLE, 8'h18);
		wr_reg(ADDR_GPIO, 8'h07);
		repeat (4) @(negedge mclk);
		chk_v("pin a drive", 8'h01, {6'h0, a_oe_n, a_out});
		wr_reg(ADDR_GPIO, 8'h01);
		repeat (4) @(negedge mclk);
		rd_chk("pin a low", ADDR_GPIO, 8'h01);
		a_val = 1'b1;
		repeat (4) @(negedge mclk);
		rd_chk("pin a high", ADDR_GPIO, 8'h05);
		a_val = 1'b0;
		wr_reg(ADDR_GPIO, 8'h38);
		repeat (4) @(negedge mclk);
		chk_v("pin b drive", 8'h01, {6'h0, b_oe_n, b_out});
		rd_reg(ADDR_FLAGS, got);
		wr_reg(ADDR_GPIO, 8'h58);
		repeat (4) @(negedge mclk);
		chk_v("pin b int idle", 8'h01, {6'h0, b_oe_n, b_out});
		stop_test();
	end
endmodule
